// ==== src/ost_pkg.sv ====
// Purpose: constants for the oscillation stabilization timer
// Assumes: one clock (clk_i, 40 MHz) standing in for the high-speed oscillator output
// Notes: register map, field positions, reset values, wait codes
// Functional notes
// - status register read-only, bit or byte reads
// - clear on reset, stop, osc-stop, clock-select
// - status 8 bits, bits 7-5 zero
// - flags set thermometer order at thresholds
// - after stop, count only during wait
// - wait count starts at oscillation start
// - cpu hold only when high-speed clock drives cpu
// - select register byte writes, reset 05H
// - select code in bits 2-0, rest zero
// - stop halts high-speed oscillator only
package ost_pkg;
  localparam logic [15:0] OST_SEL_ADDR    = 16'hFEA4; // select register address
  localparam logic [15:0] OST_STAT_ADDR   = 16'hFFA3; // status register address
  localparam logic [7:0]  OST_SEL_RESET   = 8'h05;    // select reset value
  localparam logic [7:0]  OST_STAT_RESET  = 8'h00;    // status reset value
  localparam int          OST_CODE_W      = 3;        // wait code width
  localparam int          OST_NFLAG       = 5;        // number of threshold flags
  localparam int          OST_CNT_W       = 17;       // counter reaches 2^16
  localparam logic [2:0]  OST_CODE_2P11   = 3'h1;     // wait codes
  localparam logic [2:0]  OST_CODE_2P13   = 3'h2;
  localparam logic [2:0]  OST_CODE_2P14   = 3'h3;
  localparam logic [2:0]  OST_CODE_2P15   = 3'h4;
  localparam logic [2:0]  OST_CODE_2P16   = 3'h5;
  localparam logic [16:0] OST_TH_2P11     = 17'h00800; // thresholds in osc cycles
  localparam logic [16:0] OST_TH_2P13     = 17'h02000;
  localparam logic [16:0] OST_TH_2P14     = 17'h04000;
  localparam logic [16:0] OST_TH_2P15     = 17'h08000;
  localparam logic [16:0] OST_TH_2P16     = 17'h10000;
  localparam int          OST_SYNC_STAGES = 3;        // pin synchroniser depth
endpackage

// ==== src/ost_timer.sv ====
// Purpose: stabilization counter, status/select registers, stop-release cpu hold
// Assumes: clk_i is the oscillator clock domain; osc_running_i comes from the oscillator pad
// Notes: register port is the cpu's internal byte-wide memory-manipulation path
//        after a stop release the count freezes at the selected wait until an osc-stop or clock-select clear
//        illegal wait codes act as the longest wait rather than leaving the cpu held forever
`timescale 1ns/1ps
module ost_timer (
  input  wire logic                    clk_i,           // 40 MHz, oscillator clock
  input  wire logic                    rst_b_i,         // sync reset, any reset source
  input  wire logic [15:0]             addr_i,          // cpu data address
  input  wire logic                    wr_i,            // byte write strobe
  input  wire logic                    rd_i,            // read strobe
  input  wire logic                    bit_op_i,        // access is a 1-bit instruction
  input  wire logic [2:0]              bit_sel_i,       // bit number for 1-bit access
  input  wire logic [7:0]              wdata_i,         // write data
  output logic      [7:0]              rdata_o,         // registered read data
  input  wire logic                    stop_exec_i,     // stop instruction executed, pulse
  input  wire logic                    stop_release_i,  // stop released, pulse
  input  wire logic                    main_osc_stop_bit_i,    // written one, pulse
  input  wire logic                    cpu_clock_select_bit_i, // written one, pulse
  input  wire logic                    cpu_on_hs_clk_i, // cpu runs from high-speed clock
  input  wire logic                    osc_running_i,   // oscillator pad active, async
  output logic                         osc_enable_o,    // oscillator enable
  output logic                         cpu_hold_o,      // holds cpu after stop release
  output logic [ost_pkg::OST_NFLAG-1:0] stat_o          // status flags, bit4 = 2^11
);
  import ost_pkg::*;

  // three-stage synchroniser; stage 0 read only by stage 1
  logic [OST_SYNC_STAGES-1:0] sync_ff, nxt_sync;
  logic                       run_ff, nxt_run;     // debounced oscillation-started level

  logic [7:0]           sel_ff, nxt_sel;           // select register
  logic [OST_CNT_W-1:0] cnt_ff, nxt_cnt;           // stabilization counter
  logic [OST_NFLAG-1:0] flag_ff, nxt_flag;         // thermometer flags
  logic                 wait_ff, nxt_wait;         // in post-stop wait window
  logic                 cap_ff, nxt_cap;           // count frozen at wait after stop
  logic                 hold_ff, nxt_hold;         // cpu hold output
  logic                 osc_ff, nxt_osc;           // oscillator enable
  logic [7:0]           rd_ff, nxt_rd;             // read data

  logic                 clr;                       // counter clearing event
  logic [OST_CNT_W-1:0] wait_lim;                  // selected wait in cycles

  // map a wait code to its cycle count; illegal codes fall back to longest
  function automatic logic [OST_CNT_W-1:0] code_to_cycles(input logic [2:0] code);
    unique case (code)
      OST_CODE_2P11: code_to_cycles = OST_TH_2P11;
      OST_CODE_2P13: code_to_cycles = OST_TH_2P13;
      OST_CODE_2P14: code_to_cycles = OST_TH_2P14;
      OST_CODE_2P15: code_to_cycles = OST_TH_2P15;
      OST_CODE_2P16: code_to_cycles = OST_TH_2P16;
      default:       code_to_cycles = OST_TH_2P16;
    endcase
  endfunction

  // any clearing event restarts the count
  assign clr = stop_exec_i | main_osc_stop_bit_i | cpu_clock_select_bit_i;
  assign wait_lim = code_to_cycles(sel_ff[OST_CODE_W-1:0]);

  // next-state logic for all state
  always_comb begin
    nxt_sync = {sync_ff[OST_SYNC_STAGES-2:0], osc_running_i};
    // change counts once stages 1 and 2 agree
    nxt_run  = (sync_ff[1] == sync_ff[2]) ? sync_ff[2] : run_ff;
    nxt_sel  = sel_ff;
    nxt_cnt  = cnt_ff;
    nxt_flag = flag_ff;
    nxt_wait = wait_ff;
    nxt_cap  = cap_ff;
    nxt_hold = hold_ff;
    nxt_osc  = osc_ff;
    nxt_rd   = rd_ff;

    // select register: byte writes only, bit instructions ignored
    if (wr_i && !bit_op_i && addr_i == OST_SEL_ADDR) begin
      nxt_sel = {5'h00, wdata_i[OST_CODE_W-1:0]};
    end

    // stop halts the high-speed oscillator; release restarts it
    if (stop_exec_i) begin
      nxt_osc  = 1'b0;
      nxt_wait = 1'b0;
      // drop the stale oscillation level at once; a quick release would
      // otherwise count the restart gap as if the crystal already ran
      nxt_sync = '0;
      nxt_run  = 1'b0;
    end else if (stop_release_i) begin
      nxt_osc  = 1'b1;
      nxt_wait = 1'b1;
      nxt_cap  = 1'b1;
      nxt_hold = cpu_on_hs_clk_i;
    end

    // a non-stop clear restarts a free count up to the last threshold
    if (main_osc_stop_bit_i || cpu_clock_select_bit_i) begin
      nxt_cap = 1'b0;
    end

    if (clr) begin
      nxt_cnt  = '0;
      nxt_flag = '0;
    end else if (run_ff && osc_ff) begin
      // counts only after oscillation started; after a stop release it stays
      // frozen at the selected wait so later flags never appear
      if (!(cap_ff && cnt_ff >= wait_lim) && cnt_ff != OST_TH_2P16) begin
        nxt_cnt = cnt_ff + 17'h00001;
      end
      if (wait_ff && cnt_ff >= wait_lim) begin
        nxt_wait = 1'b0;
        nxt_hold = 1'b0;
      end
      // thermometer flags, sticky until cleared
      nxt_flag = flag_ff | {cnt_ff >= OST_TH_2P11, cnt_ff >= OST_TH_2P13, cnt_ff >= OST_TH_2P14,
                            cnt_ff >= OST_TH_2P15, cnt_ff >= OST_TH_2P16};
    end

    // read mux; status is read-only, writes to it fall through
    if (rd_i) begin
      unique case (addr_i)
        OST_STAT_ADDR: nxt_rd = {3'h0, flag_ff};
        OST_SEL_ADDR:  nxt_rd = sel_ff;
        default:       nxt_rd = 8'h00;
      endcase
      if (bit_op_i) begin
        nxt_rd = {7'h00, nxt_rd[bit_sel_i]};
      end
    end
  end

  // registers only
  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      sync_ff <= '0;
      run_ff  <= 1'b0;
      sel_ff  <= OST_SEL_RESET;
      cnt_ff  <= '0;
      flag_ff <= OST_STAT_RESET[OST_NFLAG-1:0];
      wait_ff <= 1'b0;
      cap_ff  <= 1'b0;
      hold_ff <= 1'b0;
      osc_ff  <= 1'b1;
      rd_ff   <= 8'h00;
    end else begin
      sync_ff <= nxt_sync;
      run_ff  <= nxt_run;
      sel_ff  <= nxt_sel;
      cnt_ff  <= nxt_cnt;
      flag_ff <= nxt_flag;
      wait_ff <= nxt_wait;
      cap_ff  <= nxt_cap;
      hold_ff <= nxt_hold;
      osc_ff  <= nxt_osc;
      rd_ff   <= nxt_rd;
    end
  end

  assign rdata_o      = rd_ff;
  assign osc_enable_o = osc_ff;
  assign cpu_hold_o   = hold_ff;
  assign stat_o       = flag_ff;

  // assertions; each guards a register that a rule pins down

  // status flags: thermometer order, sticky, cleared together
  a_flags_thermo: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    (!flag_ff[0] || flag_ff[1]) && (!flag_ff[1] || flag_ff[2]) && (!flag_ff[2] || flag_ff[3])
    && (!flag_ff[3] || flag_ff[4]))
    else $error("flags not thermometer");
  a_flags_sticky: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    !clr && |flag_ff |=> (flag_ff & $past(flag_ff)) == $past(flag_ff))
    else $error("flag dropped");
  a_clear_event: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    clr |=> cnt_ff == '0 && flag_ff == '0)
    else $error("clear missed");
  a_first_flag: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    !clr && run_ff && osc_ff && cnt_ff == OST_TH_2P11 |=> flag_ff[4])
    else $error("2^11 flag late");

  // wait window: count capped, frozen after the wait, never started early
  a_wait_cap: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    wait_ff |-> cnt_ff <= wait_lim)
    else $error("count beyond wait");
  a_cap_freeze: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    !clr && cap_ff && cnt_ff >= wait_lim |=> cnt_ff == $past(cnt_ff))
    else $error("count ran past wait");
  a_no_osc_count: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    !clr && !run_ff |=> cnt_ff == $past(cnt_ff))
    else $error("counted before oscillation");
  a_stop_sync: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    stop_exec_i |=> !run_ff && sync_ff == '0)
    else $error("stale oscillation level");

  // cpu hold follows the clock source and the wait
  a_hold_source: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    stop_release_i && !stop_exec_i && !cpu_on_hs_clk_i |=> !cpu_hold_o)
    else $error("hold on internal clock");
  a_hold_set: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    stop_release_i && !stop_exec_i && cpu_on_hs_clk_i |=> cpu_hold_o)
    else $error("hold not raised");
  a_hold_drop: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    !clr && wait_ff && run_ff && osc_ff && cnt_ff >= wait_lim |=> !cpu_hold_o)
    else $error("hold past wait");

  // select register: byte writes only, upper bits zero
  a_sel_upper: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    sel_ff[7:3] == 5'h00)
    else $error("select upper bits set");
  a_sel_write: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    wr_i && !bit_op_i && addr_i == OST_SEL_ADDR |=> sel_ff == {5'h00, $past(wdata_i[OST_CODE_W-1:0])})
    else $error("select write lost");
  a_sel_bit_wr: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    wr_i && bit_op_i |=> sel_ff == $past(sel_ff))
    else $error("select took bit write");

  // oscillator enable around stop
  a_stop_osc: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    stop_exec_i |=> !osc_enable_o)
    else $error("oscillator not stopped");
  a_release_osc: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    stop_release_i && !stop_exec_i |=> osc_enable_o)
    else $error("oscillator not restarted");

  // read path: status byte and single-bit reads
  a_stat_upper: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    rd_i && !bit_op_i && addr_i == OST_STAT_ADDR |=> rdata_o == {3'h0, $past(flag_ff)})
    else $error("status read wrong");
  a_bit_read: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    rd_i && bit_op_i |=> rdata_o[7:1] == 7'h00)
    else $error("bit read upper bits");
endmodule

// ==== test/ost_osc_model.sv ====
// Purpose: high-speed oscillator stand-in for the stabilization timer
// Assumes: start-up takes START_CYC clocks after enable
// Notes: oscillation dies at once when the enable drops
`timescale 1ns/1ps
module ost_osc_model #(
  parameter int START_CYC = 40 // start-up delay, plain default
) (
  input  wire logic clk_i,         // bench clock
  input  wire logic osc_enable_i,  // from the timer
  output logic      osc_running_o  // oscillation present
);
  int cnt = 0; // clocks since enable
  // start-up gap is START_CYC clocks, 40 by default, so the wait window must skip it
  always @(posedge clk_i) begin
    if (!osc_enable_i) cnt <= 0;
    else if (cnt < START_CYC) cnt <= cnt + 1;
  end
  assign osc_running_o = osc_enable_i && (cnt >= START_CYC);
endmodule

// ==== test/ost_timer_tb_top.sv ====
// Purpose: self-checking bench for the stabilization timer
// Assumes: oscillator model starts 40 clocks after enable
// Notes: the full thermometer run costs about 66k clocks
`timescale 1ns/1ps
module ost_timer_tb_top;
  import ost_pkg::*;
  logic        clk_i, rst_b_i, wr_i, rd_i, bit_op_i, hs_i, run_w, en_w, hold_w;
  logic [15:0] addr_i;
  logic [7:0]  wdata_i, rdata_w;
  logic [2:0]  bit_sel_i;
  logic [3:0]  ev;      // stop, release, osc-stop, clock-select pulses
  logic [4:0]  stat_w;
  int          n_fail = 0;
  int          checks = 0;
  ost_timer ost_timer_inst (.clk_i(clk_i), .rst_b_i(rst_b_i), .addr_i(addr_i), .wr_i(wr_i), .rd_i(rd_i),
    .bit_op_i(bit_op_i), .bit_sel_i(bit_sel_i), .wdata_i(wdata_i), .rdata_o(rdata_w), .stop_exec_i(ev[0]),
    .stop_release_i(ev[1]), .main_osc_stop_bit_i(ev[2]), .cpu_clock_select_bit_i(ev[3]),
    .cpu_on_hs_clk_i(hs_i), .osc_running_i(run_w), .osc_enable_o(en_w), .cpu_hold_o(hold_w), .stat_o(stat_w));
  ost_osc_model ost_osc_model_inst (.clk_i(clk_i), .osc_enable_i(en_w), .osc_running_o(run_w));
  initial begin
    clk_i = 0;
    forever #12.5 clk_i = ~clk_i;
  end
  // inputs move 1 ns after the edge, never on it
  task tick(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask
  task chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // one-cycle strobe, then a quiet cycle so rdata has landed
  task acc(input logic w, input logic [15:0] a, input logic [7:0] d, input logic b, input logic [2:0] s);
    {wr_i, rd_i, addr_i, wdata_i, bit_op_i, bit_sel_i} = {w, !w, a, d, b, s};
    tick(1);
    {wr_i, rd_i, bit_op_i} = 3'h0;
    tick(1);
  endtask
  task rdc(input string nm, input logic [15:0] a, input logic b, input logic [2:0] s, input logic [7:0] exp);
    acc(0, a, 8'h00, b, s);
    chk(nm, rdata_w, exp);
  endtask
  task pulse(input int i);
    ev[i] = 1;
    tick(1);
    ev[i] = 0;
    tick(1);
  endtask
  task t_count;
    tick(2060);
    rdc("status_early", OST_STAT_ADDR, 0, 0, 8'h00);
    tick(60);
    rdc("status_2p11", OST_STAT_ADDR, 0, 0, 8'h10);
    rdc("bit4", OST_STAT_ADDR, 1, 4, 8'h01);
    rdc("bit3", OST_STAT_ADDR, 1, 3, 8'h00);
    tick(6200);
    chk("flags_2p13", {3'h0, stat_w}, 8'h18);
    tick(57400);
    rdc("status_full", OST_STAT_ADDR, 0, 0, 8'h1F);
    pulse(2);
    rdc("status_osc_stop", OST_STAT_ADDR, 0, 0, 8'h00);
    tick(2100);
    chk("flags_restart", {3'h0, stat_w}, 8'h10);
    pulse(3);
    chk("flags_clk_sel", {3'h0, stat_w}, 8'h00);
    $display("test count done");
  endtask
  // status already shows the wanted time before select is touched;
  // the clock-select clear just before restarted the count, so wait first
  task t_regs;
    tick(2100);
    rdc("select_reset", OST_SEL_ADDR, 0, 0, OST_SEL_RESET);
    acc(1, OST_STAT_ADDR, 8'hFF, 0, 0);
    rdc("status_ro", OST_STAT_ADDR, 0, 0, 8'h10);
    acc(1, OST_SEL_ADDR, 8'h01, 1, 0);
    rdc("select_bitwr", OST_SEL_ADDR, 0, 0, 8'h05);
    acc(1, OST_SEL_ADDR, 8'h09, 0, 0);
    rdc("select_code", OST_SEL_ADDR, 0, 0, 8'h01);
    rdc("unmapped", 16'h0000, 0, 0, 8'h00);
    $display("test regs done");
  endtask
  task t_stop(input logic hs);
    hs_i = hs;
    pulse(0);
    chk("osc_enable", {7'h0, en_w}, 8'h00);
    rdc("status_stop", OST_STAT_ADDR, 0, 0, 8'h00);
    pulse(1);
    tick(2068);
    chk("hold_mid", {7'h0, hold_w}, {7'h0, hs});
    tick(60);
    chk("hold_end", {7'h0, hold_w}, 8'h00);
    tick(6200);
    rdc("status_wait", OST_STAT_ADDR, 0, 0, 8'h10);
    $display("test stop done");
  endtask
  // mid-run reset: every register back to its reset value
  task t_reset;
    rst_b_i = 0;
    tick(10);
    rst_b_i = 1;
    chk("stat_reset", {3'h0, stat_w}, OST_STAT_RESET);
    chk("hold_reset", {7'h0, hold_w}, 8'h00);
    chk("osc_reset", {7'h0, en_w}, 8'h01);
    rdc("select_rst", OST_SEL_ADDR, 0, 0, OST_SEL_RESET);
    rdc("status_rst", OST_STAT_ADDR, 0, 0, 8'h00);
    $display("test reset done");
  endtask
  task complete_run;
    $display("checks %0d mismatches %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  initial begin
    {rst_b_i, wr_i, rd_i, bit_op_i, hs_i, ev, addr_i, wdata_i, bit_sel_i} = '0;
    tick(10);
    rst_b_i = 1;
    t_count;
    t_regs;
    t_stop(1);
    t_stop(0);
    t_reset;
    complete_run;
  end
  // about 87k clocks expected; cut off at 100k
  initial begin
    #2500000;
    n_fail++;
    complete_run;
  end
endmodule
